// *** rtl/ifpb_defines.vh ***
// Constants of the interrupt flag, enable and priority bank.
// Assumes a 32-bit AHB-Lite slave with one aligned word per register.
`ifndef IFPB_DEFINES_VH
`define IFPB_DEFINES_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define IFPB_OFS_EDGE_PULLUP_PRIORITY_CTRL 8'h00
`define IFPB_OFS_EXT_PIN_INT_CTRL 8'h04
`define IFPB_OFS_PERIPH_FLAG_A 8'h08
`define IFPB_OFS_PERIPH_FLAG_B 8'h0c
`define IFPB_OFS_PERIPH_ENABLE_A 8'h10

// ****************************************************************
// Reset values and implemented-bit masks
// ****************************************************************
`define IFPB_RST_EDGE_PULLUP_PRIORITY_CTRL 8'hf5
`define IFPB_RST_EXT_PIN_INT_CTRL 8'hc0
`define IFPB_RST_PERIPH_FLAG_A 8'h00
`define IFPB_RST_PERIPH_FLAG_B 8'h00
`define IFPB_RST_PERIPH_ENABLE_A 8'h00
`define IFPB_MSK_EDGE_PULLUP_PRIORITY_CTRL 8'hf5
`define IFPB_MSK_EXT_PIN_INT_CTRL 8'hdb
`define IFPB_MSK_PERIPH_FLAG_A_RW 8'h4f
`define IFPB_MSK_PERIPH_FLAG_A_RO 8'h30
`define IFPB_MSK_PERIPH_FLAG_B 8'hfe
`define IFPB_MSK_PERIPH_ENABLE_A 8'h7f

// ****************************************************************
// Field positions, edge_pullup_priority_ctrl
// ****************************************************************
`define IFPB_BIT_PORT_PULLUP_DISABLE 7
`define IFPB_BIT_EXT_PIN0_EDGE_SEL 6
`define IFPB_BIT_EXT_PIN1_EDGE_SEL 5
`define IFPB_BIT_EXT_PIN2_EDGE_SEL 4
`define IFPB_BIT_TIMER_ZERO_OVF_PRIO 2
`define IFPB_BIT_PORT_CHANGE_PRIO 0

// ****************************************************************
// Field positions, ext_pin_int_ctrl
// ****************************************************************
`define IFPB_BIT_EXT_PIN2_PRIO 7
`define IFPB_BIT_EXT_PIN1_PRIO 6
`define IFPB_BIT_EXT_PIN2_EN 4
`define IFPB_BIT_EXT_PIN1_EN 3
`define IFPB_BIT_EXT_PIN2_FLAG 1
`define IFPB_BIT_EXT_PIN1_FLAG 0

// ****************************************************************
// Field positions, peripheral flags
// ****************************************************************
`define IFPB_BIT_CONV_DONE 6
`define IFPB_BIT_SERIAL_RX 5
`define IFPB_BIT_SERIAL_TX 4
`define IFPB_BIT_SYNC_SERIAL 3
`define IFPB_BIT_CAPCOMP 2
`define IFPB_BIT_TIMER_TWO_MATCH 1
`define IFPB_BIT_TIMER_ONE_OVF 0
`define IFPB_BIT_OSC_FAIL 7
`define IFPB_BIT_COMPARATOR_A 6
`define IFPB_BIT_COMPARATOR_B 5
`define IFPB_BIT_NV_WRITE_DONE 4
`define IFPB_BIT_BUS_COLLISION 3
`define IFPB_BIT_USB_REQUEST 2
`define IFPB_BIT_TIMER_THREE_OVF 1

// ****************************************************************
// Vectors
// ****************************************************************
`define IFPB_VEC_HIGH 16'h0008
`define IFPB_VEC_LOW 16'h0018

`endif

// *** rtl/ifpb_bank.v ***
// Interrupt flag, enable and priority bank with an AHB-Lite register slave.
// Assumes peripheral event inputs are one-cycle pulses on ref_clk_i;
// external pins and comparator outputs are asynchronous and synchronised here.
//
// Overview of operation
// - Edge select bit one: flag on rising edge; zero: falling edge.
// - Pull-up disable bit one turns all pull-ups off; else input and enable.
// - Timer-0 and port-change priority at bits 2 and 0, one is high.
// - External pins 2/1 priority at bits 7/6, enables at bits 4/3.
// - External pin flags at bits 1/0 set on edge, cleared by software.
// - Flags set by their events regardless of any enable bit.
// - Unimplemented bits read zero and ignore writes.
// - Converter-complete flag at bit 6 set on conversion end, software clears.
// - Serial receive flag read-only, high while receive buffer holds data.
// - Serial transmit flag read-only, high while transmit buffer empty.
// - Synchronous serial flag at bit 3 set on transfer completion.
// - Capture/compare flag set on capture or compare, unused in pulse-width mode.
// - Timer-2 match sets bit 1, timer-1 overflow sets bit 0.
// - Oscillator-fail flag at bit 7 set on main oscillator failure.
// - Comparator flags at bits 6 and 5 set on output change.
// - Nonvolatile-write flag at bit 4 set when a memory write completes.
// - Bus collision flag at bit 3 set on synchronous serial collision.
// - USB flag bit 2 and timer-3 overflow flag bit 1.
// - Peripheral enables sit at the same positions as their flags.
// - Without priority levels, peripherals need the peripheral global enable.
// - With priority levels, high sources need high enable; low need both.
// - High requests vector to 0008h, low requests to 0018h.
// - Without priority levels, priority bits have no routing effect.
`include "ifpb_defines.vh"
`default_nettype none

module ifpb_bank #(
  parameter PORT_W = 8
) (
  input wire ref_clk_i,
  input wire rst_n_i,
  // AHB-Lite slave
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output wire hreadyout_o,
  output wire hresp_o,
  // External interrupt pins, asynchronous
  input wire [2:0] ext_pin_i,
  output reg ext_pin0_event_o,
  // Port pull-up control
  input wire [PORT_W-1:0] port_a_weak_pullup_sel_i,
  input wire [PORT_W-1:0] port_b_weak_pullup_sel_i,
  input wire [PORT_W-1:0] port_a_is_input_i,
  input wire [PORT_W-1:0] port_b_is_input_i,
  output reg [PORT_W-1:0] port_a_pullup_on_o,
  output reg [PORT_W-1:0] port_b_pullup_on_o,
  // Peripheral events, same clock, except the asynchronous comparator outputs
  input wire conv_done_evt_i,
  input wire serial_rx_full_i,
  input wire serial_tx_empty_i,
  input wire sync_serial_evt_i,
  input wire capcomp_evt_i,
  input wire capcomp_pwm_mode_i,
  input wire timer_two_match_evt_i,
  input wire timer_one_ovf_evt_i,
  input wire osc_fail_evt_i,
  input wire comparator_a_out_i,
  input wire comparator_b_out_i,
  input wire nv_write_done_evt_i,
  input wire bus_collision_evt_i,
  input wire usb_request_evt_i,
  input wire timer_three_ovf_evt_i,
  // Enables, priorities and global bits held by neighbouring registers
  input wire [7:0] periph_enable_b_i,
  input wire [7:0] periph_prio_a_i,
  input wire [7:0] periph_prio_b_i,
  input wire prio_levels_on_i,
  input wire high_level_global_en_i,
  input wire low_level_global_en_i,
  // Outputs toward the core
  output wire timer_zero_ovf_prio_o,
  output wire port_change_prio_o,
  output wire ext_pin0_edge_sel_o,
  output reg high_req_o,
  output reg low_req_o,
  output reg [15:0] vector_addr_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function [7:0] ifpb_merge;
    input [7:0] old_val;
    input [7:0] wdata;
    input [7:0] mask;
    input wen;
    begin
      if (wen)
        ifpb_merge = (old_val & ~mask) | (wdata & mask);
      else
        ifpb_merge = old_val;
    end
  endfunction

  function ifpb_any_level;
    input [7:0] flag;
    input [7:0] en;
    input [7:0] prio;
    input want_high;
    begin
      if (want_high)
        ifpb_any_level = |(flag & en & prio);
      else
        ifpb_any_level = |(flag & en & ~prio);
    end
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [7:0] edge_pullup_priority_ctrl_q;
  reg [7:0] edge_pullup_priority_ctrl_d;
  reg [7:0] ext_pin_int_ctrl_q;
  reg [7:0] ext_pin_int_ctrl_d;
  reg [7:0] periph_flag_a_q;
  reg [7:0] periph_flag_a_d;
  reg [7:0] periph_flag_b_q;
  reg [7:0] periph_flag_b_d;
  reg [7:0] periph_enable_a_q;
  reg [7:0] periph_enable_a_d;

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  wire addr_ok;
  wire xfer;
  wire [7:0] wbyte;
  wire wr_epp;
  wire wr_epc;
  wire wr_pfa;
  wire wr_pfb;
  wire wr_pea;
  reg [7:0] rd_sel;

  // Zero wait states; errors never signalled
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign xfer = hsel_i & htrans_i[1] & hready_i;
  assign addr_ok = (haddr_i[31:8] == 24'h000000);
  assign wbyte = hwdata_i[7:0];

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else if (hready_i)
    begin
      wr_pend_q <= xfer & hwrite_i & addr_ok;
      wr_addr_q <= haddr_i[7:0];
    end
  end

  assign wr_epp = wr_pend_q & (wr_addr_q == `IFPB_OFS_EDGE_PULLUP_PRIORITY_CTRL);
  assign wr_epc = wr_pend_q & (wr_addr_q == `IFPB_OFS_EXT_PIN_INT_CTRL);
  assign wr_pfa = wr_pend_q & (wr_addr_q == `IFPB_OFS_PERIPH_FLAG_A);
  assign wr_pfb = wr_pend_q & (wr_addr_q == `IFPB_OFS_PERIPH_FLAG_B);
  assign wr_pea = wr_pend_q & (wr_addr_q == `IFPB_OFS_PERIPH_ENABLE_A);

  // ****************************************************************
  // Pin and comparator synchronisers
  // ****************************************************************
  reg [2:0] pin_meta_q;
  reg [2:0] pin_sync_q;
  reg [2:0] pin_prev_q;
  reg [1:0] cmp_meta_q;
  reg [1:0] cmp_sync_q;
  reg [1:0] cmp_prev_q;
  reg [2:0] sync_armed_q;
  wire [2:0] edge_sel;
  wire [2:0] pin_rise;
  wire [2:0] pin_fall;
  wire [2:0] pin_evt;
  wire [1:0] cmp_chg;

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
      pin_prev_q <= 3'h0;
      cmp_meta_q <= 2'h0;
      cmp_sync_q <= 2'h0;
      cmp_prev_q <= 2'h0;
      sync_armed_q <= 3'h0;
    end
    else
    begin
      pin_meta_q <= ext_pin_i;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
      cmp_meta_q <= {comparator_b_out_i, comparator_a_out_i};
      cmp_sync_q <= cmp_meta_q;
      cmp_prev_q <= cmp_sync_q;
      sync_armed_q <= {sync_armed_q[1:0], 1'b1};
    end
  end

  assign edge_sel = {edge_pullup_priority_ctrl_q[`IFPB_BIT_EXT_PIN2_EDGE_SEL],
                     edge_pullup_priority_ctrl_q[`IFPB_BIT_EXT_PIN1_EDGE_SEL],
                     edge_pullup_priority_ctrl_q[`IFPB_BIT_EXT_PIN0_EDGE_SEL]};
  assign pin_rise = pin_sync_q & ~pin_prev_q;
  assign pin_fall = ~pin_sync_q & pin_prev_q;
  // Stale reset values in the sync chain must not look like an edge,
  // so detection waits until three edges after release
  // edge polarity select
  assign pin_evt = ((edge_sel & pin_rise) | (~edge_sel & pin_fall)) & {3{sync_armed_q[2]}};
  assign cmp_chg = (cmp_sync_q ^ cmp_prev_q) & {2{sync_armed_q[2]}};

  // ****************************************************************
  // Flag set events
  // ****************************************************************
  reg [7:0] set_a;
  reg [7:0] set_b;
  reg [7:0] set_pin;

  always @*
  begin
    set_a = 8'h00;
    set_b = 8'h00;
    set_pin = 8'h00;
    set_a[`IFPB_BIT_CONV_DONE] = conv_done_evt_i;
    set_a[`IFPB_BIT_SYNC_SERIAL] = sync_serial_evt_i;
    set_a[`IFPB_BIT_CAPCOMP] = capcomp_evt_i & ~capcomp_pwm_mode_i;
    set_a[`IFPB_BIT_TIMER_TWO_MATCH] = timer_two_match_evt_i;
    set_a[`IFPB_BIT_TIMER_ONE_OVF] = timer_one_ovf_evt_i;
    set_b[`IFPB_BIT_OSC_FAIL] = osc_fail_evt_i;
    set_b[`IFPB_BIT_COMPARATOR_A] = cmp_chg[0];
    set_b[`IFPB_BIT_COMPARATOR_B] = cmp_chg[1];
    set_b[`IFPB_BIT_NV_WRITE_DONE] = nv_write_done_evt_i;
    set_b[`IFPB_BIT_BUS_COLLISION] = bus_collision_evt_i;
    set_b[`IFPB_BIT_USB_REQUEST] = usb_request_evt_i;
    set_b[`IFPB_BIT_TIMER_THREE_OVF] = timer_three_ovf_evt_i;
    set_pin[`IFPB_BIT_EXT_PIN2_FLAG] = pin_evt[2];
    set_pin[`IFPB_BIT_EXT_PIN1_FLAG] = pin_evt[1];
  end

  // ****************************************************************
  // Next-state of the register file
  // ****************************************************************
  always @*
  begin
    // masks keep unimplemented bits at zero
    edge_pullup_priority_ctrl_d = ifpb_merge(edge_pullup_priority_ctrl_q, wbyte,
                                             `IFPB_MSK_EDGE_PULLUP_PRIORITY_CTRL, wr_epp);
    ext_pin_int_ctrl_d = ifpb_merge(ext_pin_int_ctrl_q, wbyte,
                                    `IFPB_MSK_EXT_PIN_INT_CTRL, wr_epc);
    // set wins over the clear, no enable gating
    ext_pin_int_ctrl_d = ext_pin_int_ctrl_d | set_pin;
    periph_flag_a_d = ifpb_merge(periph_flag_a_q, wbyte,
                                 `IFPB_MSK_PERIPH_FLAG_A_RW, wr_pfa) | set_a;
    periph_flag_a_d[`IFPB_BIT_SERIAL_RX] = serial_rx_full_i;
    periph_flag_a_d[`IFPB_BIT_SERIAL_TX] = serial_tx_empty_i;
    periph_flag_b_d = ifpb_merge(periph_flag_b_q, wbyte,
                                 `IFPB_MSK_PERIPH_FLAG_B, wr_pfb) | set_b;
    periph_enable_a_d = ifpb_merge(periph_enable_a_q, wbyte,
                                   `IFPB_MSK_PERIPH_ENABLE_A, wr_pea);
  end

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      edge_pullup_priority_ctrl_q <= `IFPB_RST_EDGE_PULLUP_PRIORITY_CTRL;
      ext_pin_int_ctrl_q <= `IFPB_RST_EXT_PIN_INT_CTRL;
      periph_flag_a_q <= `IFPB_RST_PERIPH_FLAG_A;
      periph_flag_b_q <= `IFPB_RST_PERIPH_FLAG_B;
      periph_enable_a_q <= `IFPB_RST_PERIPH_ENABLE_A;
    end
    else
    begin
      edge_pullup_priority_ctrl_q <= edge_pullup_priority_ctrl_d;
      ext_pin_int_ctrl_q <= ext_pin_int_ctrl_d;
      periph_flag_a_q <= periph_flag_a_d;
      periph_flag_b_q <= periph_flag_b_d;
      periph_enable_a_q <= periph_enable_a_d;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Read data comes from next-state so a write just before is seen
  always @*
  begin
    case (haddr_i[7:0])
      `IFPB_OFS_EDGE_PULLUP_PRIORITY_CTRL: rd_sel = edge_pullup_priority_ctrl_d;
      `IFPB_OFS_EXT_PIN_INT_CTRL: rd_sel = ext_pin_int_ctrl_d;
      `IFPB_OFS_PERIPH_FLAG_A: rd_sel = periph_flag_a_d;
      `IFPB_OFS_PERIPH_FLAG_B: rd_sel = periph_flag_b_d;
      `IFPB_OFS_PERIPH_ENABLE_A: rd_sel = periph_enable_a_d;
      default: rd_sel = 8'h00;
    endcase
    if (!addr_ok)
      rd_sel = 8'h00;
  end

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      hrdata_o <= 32'h00000000;
    else if (xfer & ~hwrite_i)
      hrdata_o <= {24'h000000, rd_sel};
  end

  // ****************************************************************
  // Pull-up control and pin-0 event
  // ****************************************************************
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      port_a_pullup_on_o <= {PORT_W{1'b0}};
      port_b_pullup_on_o <= {PORT_W{1'b0}};
      ext_pin0_event_o <= 1'b0;
    end
    else
    begin
      port_a_pullup_on_o <= port_a_weak_pullup_sel_i & port_a_is_input_i &
        {PORT_W{~edge_pullup_priority_ctrl_q[`IFPB_BIT_PORT_PULLUP_DISABLE]}};
      port_b_pullup_on_o <= port_b_weak_pullup_sel_i & port_b_is_input_i &
        {PORT_W{~edge_pullup_priority_ctrl_q[`IFPB_BIT_PORT_PULLUP_DISABLE]}};
      // Pin-0 flag lives in the primary control register
      ext_pin0_event_o <= pin_evt[0];
    end
  end

  assign timer_zero_ovf_prio_o = edge_pullup_priority_ctrl_q[`IFPB_BIT_TIMER_ZERO_OVF_PRIO];
  assign port_change_prio_o = edge_pullup_priority_ctrl_q[`IFPB_BIT_PORT_CHANGE_PRIO];
  assign ext_pin0_edge_sel_o = edge_pullup_priority_ctrl_q[`IFPB_BIT_EXT_PIN0_EDGE_SEL];

  // ****************************************************************
  // Request routing
  // ****************************************************************
  wire [7:0] pin_flag;
  wire [7:0] pin_en;
  wire [7:0] pin_prio;
  wire per_hi;
  wire per_lo;
  wire pin_hi;
  wire pin_lo;
  wire per_any;
  wire pin_any;
  reg high_d;
  reg low_d;

  assign pin_flag = {6'h00, ext_pin_int_ctrl_q[`IFPB_BIT_EXT_PIN2_FLAG],
                     ext_pin_int_ctrl_q[`IFPB_BIT_EXT_PIN1_FLAG]};
  assign pin_en = {6'h00, ext_pin_int_ctrl_q[`IFPB_BIT_EXT_PIN2_EN],
                   ext_pin_int_ctrl_q[`IFPB_BIT_EXT_PIN1_EN]};
  assign pin_prio = {6'h00, ext_pin_int_ctrl_q[`IFPB_BIT_EXT_PIN2_PRIO],
                     ext_pin_int_ctrl_q[`IFPB_BIT_EXT_PIN1_PRIO]};

  assign per_hi = ifpb_any_level(periph_flag_a_q, periph_enable_a_q, periph_prio_a_i, 1'b1) |
                  ifpb_any_level(periph_flag_b_q, periph_enable_b_i, periph_prio_b_i, 1'b1);
  assign per_lo = ifpb_any_level(periph_flag_a_q, periph_enable_a_q, periph_prio_a_i, 1'b0) |
                  ifpb_any_level(periph_flag_b_q, periph_enable_b_i, periph_prio_b_i, 1'b0);
  assign pin_hi = ifpb_any_level(pin_flag, pin_en, pin_prio, 1'b1);
  assign pin_lo = ifpb_any_level(pin_flag, pin_en, pin_prio, 1'b0);
  // Either level together ignores priority
  assign per_any = per_hi | per_lo;
  assign pin_any = pin_hi | pin_lo;

  always @*
  begin
    if (prio_levels_on_i)
    begin
      high_d = high_level_global_en_i & (per_hi | pin_hi);
      low_d = high_level_global_en_i & low_level_global_en_i & (per_lo | pin_lo);
    end
    else
    begin
      high_d = high_level_global_en_i & (pin_any | (low_level_global_en_i & per_any));
      low_d = 1'b0;
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      high_req_o <= 1'b0;
      low_req_o <= 1'b0;
      vector_addr_o <= `IFPB_VEC_HIGH;
    end
    else
    begin
      high_req_o <= high_d;
      low_req_o <= low_d;
      if (!high_d & low_d)
        vector_addr_o <= `IFPB_VEC_LOW;
      else
        vector_addr_o <= `IFPB_VEC_HIGH;
    end
  end

endmodule

`default_nettype wire

// *** testbench/ifpb_periph_model.sv ***
// Model of the peripherals that raise events toward the bank.
// Assumes the bench calls pulse just after a rising clock edge.
`default_nettype none
module ifpb_periph_model (
  input wire logic clk_i,
  output logic [9:0] evt_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial evt_o = '0;
  task automatic pulse(input int k);
    evt_o[k] <= 1'b1;
    @(posedge clk_i);
    evt_o[k] <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** testbench/ifpb_bank_chk.sv ***
// Concurrent checks on the bank's ports.
// Assumes one clock domain; bound to every bank instance below.
`default_nettype none
module ifpb_bank_chk #(
  parameter PORT_W = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [31:0] hrdata_o,
  input wire logic [2:0] ext_pin_i,
  input wire logic ext_pin0_event_o,
  input wire logic ext_pin0_edge_sel_o,
  input wire logic [PORT_W-1:0] port_a_weak_pullup_sel_i,
  input wire logic [PORT_W-1:0] port_a_is_input_i,
  input wire logic [PORT_W-1:0] port_a_pullup_on_o,
  input wire logic prio_levels_on_i,
  input wire logic high_level_global_en_i,
  input wire logic low_level_global_en_i,
  input wire logic high_req_o,
  input wire logic low_req_o,
  input wire logic [15:0] vector_addr_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  chk_upper_zero: assert property (hrdata_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_low_vector: assert property (low_req_o && !high_req_o |-> vector_addr_o == 16'h0018)
    else $error("low request with wrong vector");
  chk_high_vector: assert property (high_req_o |-> vector_addr_o == 16'h0008)
    else $error("high request with wrong vector");
  chk_compat_low: assert property (!prio_levels_on_i |=> !low_req_o)
    else $error("low request without priority levels");
  chk_high_gate: assert property (!high_level_global_en_i |=> !high_req_o)
    else $error("high request while high enable off");
  chk_low_gate: assert property (prio_levels_on_i && !low_level_global_en_i |=> !low_req_o)
    else $error("low request while low enable off");
  chk_pullup_gate: assert property (1'b1 |=> (port_a_pullup_on_o
    & ~$past(port_a_weak_pullup_sel_i & port_a_is_input_i)) == '0)
    else $error("pull-up on for output or unselected pin");
  chk_pin_edge: assert property (ext_pin0_event_o |->
    $past(ext_pin_i[0], 3) == $past(ext_pin0_edge_sel_o))
    else $error("pin event on unselected edge");
  chk_pin_pulse: assert property (ext_pin0_event_o |=> !ext_pin0_event_o)
    else $error("pin event longer than one cycle");
  cov_high: cover property (high_req_o);
  cov_low: cover property (low_req_o && !high_req_o);
  cov_pin: cover property (ext_pin0_event_o);
endmodule
bind ifpb_bank ifpb_bank_chk #(.PORT_W(PORT_W)) ifpb_bank_chk_i (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .hrdata_o(hrdata_o), .ext_pin_i(ext_pin_i),
  .ext_pin0_event_o(ext_pin0_event_o), .ext_pin0_edge_sel_o(ext_pin0_edge_sel_o),
  .port_a_weak_pullup_sel_i(port_a_weak_pullup_sel_i),
  .port_a_is_input_i(port_a_is_input_i), .port_a_pullup_on_o(port_a_pullup_on_o),
  .prio_levels_on_i(prio_levels_on_i), .high_level_global_en_i(high_level_global_en_i),
  .low_level_global_en_i(low_level_global_en_i), .high_req_o(high_req_o),
  .low_req_o(low_req_o), .vector_addr_o(vector_addr_o));
`default_nettype wire

// *** testbench/ifpb_bank_tb_top.sv ***
// Self-checking bench for the interrupt flag, enable and priority bank.
// Assumes the peripheral model and the bound checker compile beside it.
`default_nettype none
module ifpb_bank_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, rdy, resp, ev0, es0, tz, pc, hreq, lreq;
  logic rxf = 0, txe = 1, pwm = 0, cma = 0, cmb = 0, prio_levels_on = 0, gh = 0, gl = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2, pin = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [7:0] sel = 8'hff, inp = 8'h0f, pua, pub, en_b = 8'h00, pr_a = 8'h00, pr_b = 8'h00;
  logic [9:0] evt;
  logic [15:0] vec;
  logic [7:0] rst_v [5] = '{8'hf5, 8'hc0, 8'h10, 8'h00, 8'h00};
  logic [7:0] one_v [5] = '{8'hf5, 8'hdb, 8'h5f, 8'hfe, 8'h7f};
  logic [7:0] ev_b [10] = '{8'h40, 8'h08, 8'h04, 8'h02, 8'h01, 8'h80, 8'h10, 8'h08, 8'h04, 8'h02};
  int failures = 0, comparisons = 0;
  ifpb_bank ifpb_bank_i (
    .ref_clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(rdy), .hrdata_o(hrdata),
    .hreadyout_o(rdy), .hresp_o(resp), .ext_pin_i(pin), .ext_pin0_event_o(ev0),
    .port_a_weak_pullup_sel_i(sel), .port_b_weak_pullup_sel_i(~sel),
    .port_a_is_input_i(inp), .port_b_is_input_i(inp), .port_a_pullup_on_o(pua),
    .port_b_pullup_on_o(pub), .conv_done_evt_i(evt[0]), .serial_rx_full_i(rxf),
    .serial_tx_empty_i(txe), .sync_serial_evt_i(evt[1]), .capcomp_evt_i(evt[2]),
    .capcomp_pwm_mode_i(pwm), .timer_two_match_evt_i(evt[3]), .timer_one_ovf_evt_i(evt[4]),
    .osc_fail_evt_i(evt[5]), .comparator_a_out_i(cma), .comparator_b_out_i(cmb),
    .nv_write_done_evt_i(evt[6]), .bus_collision_evt_i(evt[7]), .usb_request_evt_i(evt[8]),
    .timer_three_ovf_evt_i(evt[9]), .periph_enable_b_i(en_b), .periph_prio_a_i(pr_a),
    .periph_prio_b_i(pr_b), .prio_levels_on_i(prio_levels_on), .high_level_global_en_i(gh),
    .low_level_global_en_i(gl), .timer_zero_ovf_prio_o(tz), .port_change_prio_o(pc),
    .ext_pin0_edge_sel_o(es0), .high_req_o(hreq), .low_req_o(lreq), .vector_addr_o(vec));
  ifpb_periph_model ifpb_periph_model_i (.clk_i(clk), .evt_o(evt));
  initial forever #2.5 clk = ~clk;
  task automatic give_verdict;
    $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      failures++;
  endtask
  // Bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int n = 0;
    @(posedge clk);
    while (rdy !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (rdy !== 1'b1)
    begin
      failures++;
      $display("ERROR at %0t: bus wait timed out", $time);
      give_verdict;
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 32'h0);
    check(rd, {24'h0, e});
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("ERROR at %0t: run timed out", $time);
    give_verdict;
  end
  initial
  begin
    logic [7:0] a;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    check({tz, pc, es0}, 3'b111);
    for (int i = 0; i < 5; i++)
      rchk(8'(4 * i), rst_v[i]);
    $display("Test reset values done");
    for (int i = 0; i < 6; i++)
    begin
      xfer(1'b1, 8'(4 * i), 32'hffffffff);
      rchk(8'(4 * i), i < 5 ? one_v[i] : 8'h00);
      check(resp, 1'b0);
    end
    for (int i = 0; i < 5; i++)
      xfer(1'b1, 8'(4 * i), 32'h0);
    check({tz, pc, pua, pub}, 18'h00f00);
    xfer(1'b1, 8'h00, 32'h80);
    rchk(8'h00, 8'h80);
    check(pua, 8'h00);
    $display("Test access and pull-ups done");
    pin <= 3'b011;
    repeat (8) @(posedge clk);
    rchk(8'h04, 8'h00);
    pin <= 3'b000;
    repeat (8) @(posedge clk);
    rchk(8'h04, 8'h01);
    xfer(1'b1, 8'h00, 32'h70);
    pin <= 3'b100;
    repeat (8) @(posedge clk);
    rchk(8'h04, 8'h03);
    xfer(1'b1, 8'h04, 32'h0);
    rchk(8'h04, 8'h00);
    $display("Test external pins done");
    for (int i = 0; i < 10; i++)
    begin
      a = i < 5 ? 8'h08 : 8'h0c;
      ifpb_periph_model_i.pulse(i);
      rchk(a, ev_b[i] | (i < 5 ? 8'h10 : 8'h00));
      xfer(1'b1, a, 32'h0);
      rchk(a, i < 5 ? 8'h10 : 8'h00);
    end
    pwm <= 1'b1;
    ifpb_periph_model_i.pulse(2);
    rchk(8'h08, 8'h10);
    pwm <= 1'b0;
    cma <= 1'b1;
    cmb <= 1'b1;
    repeat (6) @(posedge clk);
    rchk(8'h0c, 8'h60);
    xfer(1'b1, 8'h0c, 32'h0);
    cmb <= 1'b0;
    repeat (6) @(posedge clk);
    rchk(8'h0c, 8'h20);
    xfer(1'b1, 8'h0c, 32'h0);
    $display("Test event flags done");
    rxf <= 1'b1;
    txe <= 1'b0;
    xfer(1'b1, 8'h08, 32'h10);
    rchk(8'h08, 8'h20);
    rxf <= 1'b0;
    txe <= 1'b1;
    $display("Test serial mirrors done");
    xfer(1'b1, 8'h08, 32'h0);
    xfer(1'b1, 8'h10, 32'h40);
    ifpb_periph_model_i.pulse(0);
    gh <= 1'b1;
    repeat (2) @(posedge clk);
    check({hreq, lreq}, 2'b00);
    gl <= 1'b1;
    repeat (2) @(posedge clk);
    check({hreq, lreq, vec}, {2'b10, 16'h0008});
    prio_levels_on <= 1'b1;
    repeat (2) @(posedge clk);
    check({hreq, lreq, vec}, {2'b01, 16'h0018});
    gl <= 1'b0;
    repeat (2) @(posedge clk);
    check({hreq, lreq}, 2'b00);
    pr_a <= 8'h40;
    repeat (2) @(posedge clk);
    check({hreq, lreq, vec}, {2'b10, 16'h0008});
    $display("Test requests done");
    give_verdict;
  end
endmodule
`default_nettype wire
